/* File: hdl/cwrw_cfg.svh */
// Constants of the config word and regulator wake controller.
// Assumes inclusion by bare name from the top module, the checker and the bench.
`ifndef CWRW_CFG_SVH
`define CWRW_CFG_SVH
// ------------
// Register byte offsets on the AHB-Lite bus
// ------------
`define CWRW_OFS_CW3      8'h00
`define CWRW_OFS_CW4      8'h04
`define CWRW_OFS_PARTID   8'h08
`define CWRW_OFS_REV      8'h0c
`define CWRW_OFS_RESET_CONTROL_REG     8'h10
`define CWRW_OFS_IRQ_FLAG_STATUS_FOUR     8'h14
`define CWRW_OFS_MASK     8'h18
`define CWRW_OFS_PROT     8'h1c
// ------------
// Field positions
// ------------
`define CWRW_B_END_SEL    15
`define CWRW_B_CFG_PROT   14
`define CWRW_B_SEG_DIS    13
`define CWRW_F_WAKE_HI    11
`define CWRW_F_WAKE_LO    10
`define CWRW_F_SOSC_HI    9
`define CWRW_F_SOSC_LO    8
`define CWRW_B_KEEPALIVE  8
`define CWRW_B_BROWNOUT   1
`define CWRW_B_LVD        8
`define CWRW_B_WAKE_DONE  0
// ------------
// Codes and reset values
// ------------
`define CWRW_WAKE_FAST    2'b01
`define CWRW_SOSC_HIGH    2'b11
`define CWRW_SOSC_LOW     2'b01
`define CWRW_SOSC_EXT     2'b00
`define CWRW_FAMILY_ID    8'h5a
`define CWRW_PART_ID      8'h3c
`define CWRW_REVISION     4'h1
`define CWRW_LAST_PAGE    8'hff
`define CWRW_RESET_CONTROL_REG_RST     1'b0
`define CWRW_MASK_RST     9'h000
`define CWRW_STAT_MASK    9'h103
// ------------
// Timing: regulator wake delay in ns, clock period in ns
// ------------
`define CWRW_CLK_NS       4
`define CWRW_REGULATOR_WAKE_DELAY_NS     10000
`define CWRW_REGULATOR_WAKE_DELAY_FAST_NS 5000
`define CWRW_REGULATOR_WAKE_DELAY_CYC    12'((`CWRW_REGULATOR_WAKE_DELAY_NS + `CWRW_CLK_NS - 1) / `CWRW_CLK_NS)
`define CWRW_REGULATOR_WAKE_DELAY_FAST_CYC 12'((`CWRW_REGULATOR_WAKE_DELAY_FAST_NS + `CWRW_CLK_NS - 1) / `CWRW_CLK_NS)
`endif

/* File: hdl/cwrw_pkg.sv */
// Types of the config word and regulator wake controller.
// Assumes nothing of its surroundings.
package cwrw_pkg;
    // Power sequencing states.
    typedef enum logic [2:0] {
        ST_POWERUP,
        ST_RUN,
        ST_SLEEP,
        ST_WAKE,
        ST_BROWNOUT
    } cwrw_state_t;
    // Decoded secondary oscillator modes.
    typedef enum logic [1:0] {
        SOSC_HIGH_DRIVE,
        SOSC_LOW_DRIVE,
        SOSC_EXT_DIGITAL,
        SOSC_RESERVED
    } cwrw_sosc_t;
endpackage : cwrw_pkg

/* File: hdl/cwrw_top.sv */
// Config word decoder, identification registers and regulator wake control.
// Assumes an AHB-Lite master on i_ref_clk and static config words from
// nonvolatile storage, captured once after reset release.
//
// Our own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "cwrw_cfg.svh"

// What this block does
// - Wake select 11 default, 01 fast
// - Oscillator select: high, low, external/digital
// - End-select 1: boundary page to last
// - End-select 0: page zero to boundary
// - Config page protected on end-select or match
// - Word four upper byte reads zero
// - Identification: family, part, upper bits one
// - Revision in low nibble, rest zero
// - Regulator falling sets low-voltage flag
// - Hold execution for wake delay on resume
// - Delay chosen by keepalive and wake select
// - Low supply: brown-out reset and flag
// - Keepalive clear: standby during sleep
// - Wake from standby waits wake delay
// - Keepalive set: no standby, no delay
module cwrw_top (
    input  wire logic               i_ref_clk,
    input  wire logic               i_rstn,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic               hready,
    input  wire logic [31:0]        hwdata,
    output logic                    hreadyout,
    output logic                    hresp,
    output logic [31:0]             hrdata,
    input  wire logic [23:0]        i_config_word_three,
    input  wire logic [23:0]        i_config_word_four,
    input  wire logic               i_regulator_enable_pin,
    input  wire logic               i_low_voltage_det,
    input  wire logic               i_supply_low_det,
    input  wire logic               i_sleep_req,
    input  wire logic               i_wake_evt,
    output logic                    o_core_run,
    output logic                    o_regulator_standby,
    output logic                    o_brownout_rst,
    output cwrw_pkg::cwrw_sosc_t    o_secondary_osc_mode,
    output logic                    o_secondary_clock_input_digital,
    output logic                    o_segment_protect_en,
    output logic [7:0]              o_protect_lo_page,
    output logic [7:0]              o_protect_hi_page,
    output logic                    o_config_page_protected,
    output logic                    o_irq
);
    import cwrw_pkg::*;

    // ------------
    // Pin synchronisers
    // ------------
    logic [2:0]  pin_s1_q;
    logic [2:0]  pin_s2_q;
    logic [2:0]  pin_s3_q;
    logic [2:0]  pin_q;
    wire logic [2:0] pin_raw = {i_supply_low_det, i_low_voltage_det, i_regulator_enable_pin};

    // Three stages per pin; the level moves only when stages two and three agree.
    for (genvar g = 0; g < 3; g++) begin : g_sync
        always_ff @(posedge i_ref_clk or negedge i_rstn) begin
            if (!i_rstn) begin
                pin_s1_q[g] <= 1'b0;
                pin_s2_q[g] <= 1'b0;
                pin_s3_q[g] <= 1'b0;
                pin_q[g]    <= 1'b0;
            end else begin
                pin_s1_q[g] <= pin_raw[g];
                pin_s2_q[g] <= pin_s1_q[g];
                pin_s3_q[g] <= pin_s2_q[g];
                if (pin_s2_q[g] == pin_s3_q[g]) begin
                    pin_q[g] <= pin_s3_q[g];
                end
            end
        end
    end

    logic      lvd_prev_q;
    wire logic reg_en     = pin_q[0];
    wire logic lvd_lvl    = pin_q[1];
    wire logic supply_low = pin_q[2];

    // ------------
    // Config word capture
    // ------------
    logic        cfg_loaded_q;
    logic [15:0] cw3_q;
    logic [15:0] cw4_q;

    // The words are straps: taken on the first edge after reset release.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cfg_loaded_q <= 1'b0;
            cw3_q        <= 16'hffff;
            cw4_q        <= 16'hffff;
        end else if (!cfg_loaded_q) begin
            cfg_loaded_q <= 1'b1;
            cw3_q        <= i_config_word_three[15:0];
            cw4_q        <= i_config_word_four[15:0];
        end
    end

    logic [1:0] regulator_wake_time_sel;
    logic [1:0] secondary_osc_drive_sel;
    logic [7:0] protect_boundary_page;
    logic       protect_end_select;
    logic       config_page_protect;
    logic       seg_disable;

    assign regulator_wake_time_sel = cw3_q[`CWRW_F_WAKE_HI:`CWRW_F_WAKE_LO];
    assign secondary_osc_drive_sel = cw3_q[`CWRW_F_SOSC_HI:`CWRW_F_SOSC_LO];
    assign protect_boundary_page   = cw3_q[7:0];
    assign protect_end_select      = cw3_q[`CWRW_B_END_SEL];
    assign config_page_protect     = cw3_q[`CWRW_B_CFG_PROT];
    assign seg_disable             = cw3_q[`CWRW_B_SEG_DIS];

    // ------------
    // Config word decode outputs
    // ------------
    // Oscillator mode; the reserved code is flagged rather than guessed.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_secondary_osc_mode            <= SOSC_HIGH_DRIVE;
            o_secondary_clock_input_digital <= 1'b0;
        end else begin
            case (secondary_osc_drive_sel)
                `CWRW_SOSC_HIGH: o_secondary_osc_mode <= SOSC_HIGH_DRIVE;
                `CWRW_SOSC_LOW:  o_secondary_osc_mode <= SOSC_LOW_DRIVE;
                `CWRW_SOSC_EXT:  o_secondary_osc_mode <= SOSC_EXT_DIGITAL;
                default:         o_secondary_osc_mode <= SOSC_RESERVED;
            endcase
            // Tells the pin mux to make the secondary clock pin a digital input.
            o_secondary_clock_input_digital <= (secondary_osc_drive_sel == `CWRW_SOSC_EXT);
        end
    end

    // Protected segment bounds, inclusive of the boundary page.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_segment_protect_en    <= 1'b0;
            o_protect_lo_page       <= 8'h00;
            o_protect_hi_page       <= 8'h00;
            o_config_page_protected <= 1'b0;
        end else begin
            o_segment_protect_en <= !seg_disable;
            if (protect_end_select) begin
                o_protect_lo_page <= protect_boundary_page;
                o_protect_hi_page <= `CWRW_LAST_PAGE;
            end else begin
                o_protect_lo_page <= 8'h00;
                o_protect_hi_page <= protect_boundary_page;
            end
            o_config_page_protected <= !seg_disable && (protect_end_select ||
                (protect_boundary_page == `CWRW_LAST_PAGE) || !config_page_protect);
        end
    end

    // ------------
    // Regulator wake sequencer
    // ------------
    cwrw_state_t state_q;
    logic [11:0] hold_cnt_q;
    logic        keepalive_q;
    logic        wake_done_evt;
    logic [11:0] wake_cycles;

    // Standby wake length; reserved codes fall back to the longer delay.
    assign wake_cycles = (regulator_wake_time_sel == `CWRW_WAKE_FAST) ?
                         `CWRW_REGULATOR_WAKE_DELAY_FAST_CYC : `CWRW_REGULATOR_WAKE_DELAY_CYC;

    // Core is released when the hold-off counter runs out, or at once on a wake with keepalive set or the regulator off.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q    <= ST_POWERUP;
            hold_cnt_q <= `CWRW_REGULATOR_WAKE_DELAY_CYC;
        end else begin
            case (state_q)
                ST_POWERUP: begin
                    if (supply_low && reg_en) begin
                        state_q <= ST_BROWNOUT;
                    end else if (!reg_en || !cfg_loaded_q) begin
                        hold_cnt_q <= `CWRW_REGULATOR_WAKE_DELAY_CYC;
                    end else if (hold_cnt_q == 12'h001) begin
                        state_q <= ST_RUN;
                    end else begin
                        hold_cnt_q <= hold_cnt_q - 12'h001;
                    end
                end
                ST_RUN: begin
                    if (supply_low && reg_en) begin
                        state_q <= ST_BROWNOUT;
                    end else if (i_sleep_req) begin
                        state_q <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (supply_low && reg_en) begin
                        state_q <= ST_BROWNOUT;
                    end else if (i_wake_evt) begin
                        if (keepalive_q || !reg_en) begin
                            state_q <= ST_RUN;
                        end else begin
                            state_q    <= ST_WAKE;
                            hold_cnt_q <= wake_cycles;
                        end
                    end
                end
                ST_WAKE: begin
                    if (supply_low && reg_en) begin
                        state_q <= ST_BROWNOUT;
                    end else if (hold_cnt_q == 12'h001) begin
                        state_q <= ST_RUN;
                    end else begin
                        hold_cnt_q <= hold_cnt_q - 12'h001;
                    end
                end
                ST_BROWNOUT: begin
                    if (!supply_low) begin
                        state_q    <= ST_POWERUP;
                        hold_cnt_q <= `CWRW_REGULATOR_WAKE_DELAY_CYC;
                    end
                end
                default: begin
                    state_q <= ST_POWERUP;
                end
            endcase
        end
    end

    assign wake_done_evt = (hold_cnt_q == 12'h001) && !(supply_low && reg_en) &&
                           ((state_q == ST_WAKE) || ((state_q == ST_POWERUP) && reg_en && cfg_loaded_q));

    // Sequencer outputs, registered.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_core_run          <= 1'b0;
            o_regulator_standby <= 1'b0;
            o_brownout_rst      <= 1'b0;
        end else begin
            o_core_run          <= (state_q == ST_RUN);
            o_regulator_standby <= (state_q == ST_SLEEP) && !keepalive_q && reg_en;
            o_brownout_rst      <= (state_q == ST_BROWNOUT);
        end
    end

    // ------------
    // AHB-Lite slave
    // ------------
    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;
    logic        acc_take;
    logic [8:0]  status_q;
    logic [8:0]  mask_q;
    logic [8:0]  status_set;
    logic [8:0]  status_clr;
    logic [31:0] rd_mux;

    assign acc_take = hsel && hready && htrans[1];

    // Address phase is latched; writes complete in the following data phase.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= acc_take && hwrite;
            if (acc_take) begin
                wr_addr_q <= haddr[7:0];
            end
        end
    end

    // Read data for the selected word; unmapped offsets read as zero.
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (haddr[7:0])
            `CWRW_OFS_CW3:    rd_mux = {16'h0000, cw3_q};
            `CWRW_OFS_CW4:    rd_mux = {16'h0000, cw4_q};
            `CWRW_OFS_PARTID: rd_mux = {8'h00, 8'hff, `CWRW_FAMILY_ID, `CWRW_PART_ID};
            `CWRW_OFS_REV:    rd_mux = {28'h0000000, `CWRW_REVISION};
            `CWRW_OFS_RESET_CONTROL_REG:   rd_mux = {23'h000000, keepalive_q, 6'h00, status_q[`CWRW_B_BROWNOUT], 1'b0};
            `CWRW_OFS_IRQ_FLAG_STATUS_FOUR:   rd_mux = {23'h000000, status_q};
            `CWRW_OFS_MASK:   rd_mux = {23'h000000, mask_q};
            `CWRW_OFS_PROT:   rd_mux = {14'h0000, o_config_page_protected, o_segment_protect_en,
                                        o_protect_hi_page, o_protect_lo_page};
            default:          rd_mux = 32'h0000_0000;
        endcase
    end

    // Zero-wait slave, always OKAY.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (acc_take && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    // ------------
    // Control and status registers
    // ------------
    // Keepalive control and interrupt mask written by software.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            keepalive_q <= `CWRW_RESET_CONTROL_REG_RST;
            mask_q      <= `CWRW_MASK_RST;
        end else if (wr_pend_q) begin
            if (wr_addr_q == `CWRW_OFS_RESET_CONTROL_REG) begin
                keepalive_q <= hwdata[`CWRW_B_KEEPALIVE];
            end
            if (wr_addr_q == `CWRW_OFS_MASK) begin
                mask_q <= hwdata[8:0] & `CWRW_STAT_MASK;
            end
        end
    end

    // Events: falling regulator output, brown-out, end of wake hold-off.
    always_comb begin
        status_set                     = 9'h000;
        status_set[`CWRW_B_LVD]        = lvd_lvl && !lvd_prev_q;
        status_set[`CWRW_B_BROWNOUT]   = (state_q != ST_BROWNOUT) && supply_low && reg_en;
        status_set[`CWRW_B_WAKE_DONE]  = wake_done_evt;
        status_clr                     = 9'h000;
        if (wr_pend_q && (wr_addr_q == `CWRW_OFS_IRQ_FLAG_STATUS_FOUR)) begin
            status_clr = hwdata[8:0] & `CWRW_STAT_MASK;
        end
        if (wr_pend_q && (wr_addr_q == `CWRW_OFS_RESET_CONTROL_REG)) begin
            status_clr[`CWRW_B_BROWNOUT] = hwdata[`CWRW_B_BROWNOUT];
        end
    end

    // Sticky flags; a new event beats a same-cycle clear.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            status_q   <= 9'h000;
            lvd_prev_q <= 1'b0;
        end else begin
            status_q   <= (status_q & ~status_clr) | status_set;
            lvd_prev_q <= lvd_lvl;
        end
    end

    // Level interrupt while any unmasked flag is set.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(((status_q & ~status_clr) | status_set) & mask_q);
        end
    end

endmodule : cwrw_top

/* File: sim/cwrw_asserts.sv */
// Concurrent checks on the ports of the config word and wake controller.
// Assumes one clock domain and the register map of cwrw_cfg.svh.
`timescale 1ns/10ps
`include "cwrw_cfg.svh"
module cwrw_asserts (
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_rstn,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic                 hready,
    input  wire logic [31:0]          hrdata,
    input  wire logic                 i_regulator_enable_pin,
    input  wire logic                 i_supply_low_det,
    input  wire logic                 o_core_run,
    input  wire logic                 o_regulator_standby,
    input  wire logic                 o_brownout_rst,
    input  cwrw_pkg::cwrw_sosc_t      o_secondary_osc_mode,
    input  wire logic                 o_secondary_clock_input_digital,
    input  wire logic                 o_segment_protect_en,
    input  wire logic [7:0]           o_protect_lo_page,
    input  wire logic [7:0]           o_protect_hi_page,
    input  wire logic                 o_config_page_protected
);
    import cwrw_pkg::*;
    // ------------
    // Helper logic
    // ------------
    logic [11:0] up_q;
    wire         rd_take = hsel && hready && htrans[1] && !hwrite;
    // Counts cycles since reset release and saturates, so early run is visible.
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) up_q <= 12'h000;
        else if (up_q != 12'hfff) up_q <= up_q + 12'h001;
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    // ------------
    // Assertions
    // ------------
    osc_digital_a: assert property (o_secondary_clock_input_digital == (o_secondary_osc_mode == SOSC_EXT_DIGITAL))
        else $error("pin flag and mode differ");
    seg_bounds_a: assert property (o_protect_lo_page == 8'h00 || o_protect_hi_page == 8'hff)
        else $error("segment touches no end");
    cfg_top_a: assert property (o_segment_protect_en && o_protect_hi_page == 8'hff |-> o_config_page_protected)
        else $error("config page open");
    cfg_only_a: assert property (o_config_page_protected |-> o_segment_protect_en)
        else $error("protected with segments off");
    standby_core_a: assert property (o_regulator_standby |-> !o_core_run)
        else $error("core runs in standby");
    brown_core_a: assert property (o_brownout_rst |-> !o_core_run)
        else $error("core runs in brown-out");
    brown_entry_a: assert property ((i_supply_low_det && i_regulator_enable_pin) [*8] |-> ##[0:4] o_brownout_rst)
        else $error("no brown-out reset");
    early_run_a: assert property (up_q < 12'h9c4 |-> !o_core_run)
        else $error("core released early");
    id_read_a: assert property (rd_take && haddr[7:0] == `CWRW_OFS_PARTID
        |=> hrdata == {8'h00, 8'hff, `CWRW_FAMILY_ID, `CWRW_PART_ID})
        else $error("id read wrong");
    rev_read_a: assert property (rd_take && haddr[7:0] == `CWRW_OFS_REV |=> hrdata == {28'h0, `CWRW_REVISION})
        else $error("revision read wrong");
    cw4_top_a: assert property (rd_take && haddr[7:0] == `CWRW_OFS_CW4 |=> hrdata[31:16] == 16'h0000)
        else $error("word four top bits set");
    cover property ($rose(o_core_run));
    cover property (o_regulator_standby);
    cover property (o_brownout_rst);
endmodule : cwrw_asserts

bind cwrw_top cwrw_asserts u_chk (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .i_regulator_enable_pin(i_regulator_enable_pin),
    .i_supply_low_det(i_supply_low_det), .o_core_run(o_core_run), .o_regulator_standby(o_regulator_standby),
    .o_brownout_rst(o_brownout_rst), .o_secondary_osc_mode(o_secondary_osc_mode),
    .o_secondary_clock_input_digital(o_secondary_clock_input_digital),
    .o_segment_protect_en(o_segment_protect_en), .o_protect_lo_page(o_protect_lo_page),
    .o_protect_hi_page(o_protect_hi_page), .o_config_page_protected(o_config_page_protected)
);

/* File: sim/config_word_and_regulator_wake_ctrl_test.sv */
// Self-checking bench for the config word and regulator wake controller.
// Assumes cwrw_top with its checker bound and a 250 MHz reference clock.
`timescale 1ns/10ps
`include "cwrw_cfg.svh"
module config_word_and_regulator_wake_ctrl_test;
    import cwrw_pkg::*;
    logic        i_ref_clk, i_rstn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [23:0] cw3, cw4;
    logic        en_pin, lv_det, sl_det, sleep_req, wake_evt;
    logic        core_run, standby, brown_rst, dig_pin, seg_en, cfg_prot, irq;
    logic [7:0]  lo_pg, hi_pg;
    cwrw_sosc_t  osc_mode;
    int          bad_count, total_checks, n;
    wire         hready = hreadyout;

    cwrw_top dut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .i_config_word_three(cw3), .i_config_word_four(cw4),
        .i_regulator_enable_pin(en_pin), .i_low_voltage_det(lv_det), .i_supply_low_det(sl_det),
        .i_sleep_req(sleep_req), .i_wake_evt(wake_evt), .o_core_run(core_run),
        .o_regulator_standby(standby), .o_brownout_rst(brown_rst), .o_secondary_osc_mode(osc_mode),
        .o_secondary_clock_input_digital(dig_pin), .o_segment_protect_en(seg_en),
        .o_protect_lo_page(lo_pg), .o_protect_hi_page(hi_pg), .o_config_page_protected(cfg_prot),
        .o_irq(irq));

    // Free-running reference clock, 4 ns period.
    initial begin
        i_ref_clk = 1'b0;
        forever #2 i_ref_clk = ~i_ref_clk;
    end
    // ------------
    // Shared tasks
    // ------------
    // Counts every comparison and reports a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One single AHB-Lite transfer; the data phase ends on the second ready edge.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge i_ref_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge i_ref_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge i_ref_clk); while (hready !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask : xfer
    task automatic rd32(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rd32
    // Holds reset four cycles with a new strap word; word four keeps all ones.
    task automatic rst(input logic [15:0] w3);
        @(posedge i_ref_clk);
        i_rstn <= 1'b0;
        cw3 <= {8'hff, w3};
        cw4 <= 24'hffffff;
        repeat (4) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
    endtask : rst
    // Counts cycles to core release and checks the window.
    task automatic wait_run(input int lo, input int hi);
        n = 0;
        while (core_run !== 1'b1 && n < 4000) begin
            @(posedge i_ref_clk);
            n++;
        end
        chk(32'((n >= lo && n <= hi) ? lo : n), 32'(lo));
    endtask : wait_run
    // ------------
    // Scenarios
    // ------------
    // Five strap words: legal oscillator codes, both end selects, page match.
    task automatic t_decode();
        logic [15:0] w[5] = '{16'hdf3c, 16'h5520, 16'h1c10, 16'h5dff, 16'hffff};
        logic [7:0]  lo, hi;
        logic        cp;
        cwrw_sosc_t  m;
        foreach (w[i]) begin
            rst(w[i]);
            lo = w[i][15] ? w[i][7:0] : 8'h00;
            hi = w[i][15] ? 8'hff : w[i][7:0];
            cp = !w[i][13] && (w[i][15] || !w[i][14] || w[i][7:0] == 8'hff);
            case (w[i][9:8])
                2'b11: m = SOSC_HIGH_DRIVE;
                2'b01: m = SOSC_LOW_DRIVE;
                2'b00: m = SOSC_EXT_DIGITAL;
                default: m = SOSC_RESERVED;
            endcase
            chk({30'h0, osc_mode}, {30'h0, m});
            chk({31'h0, dig_pin}, {31'h0, w[i][9:8] == 2'b00});
            chk({16'h0, hi_pg, lo_pg}, {16'h0, hi, lo});
            chk({30'h0, seg_en, cfg_prot}, {30'h0, !w[i][13], cp});
            rd32(`CWRW_OFS_PROT, {14'h0, cp, !w[i][13], hi, lo});
            rd32(`CWRW_OFS_CW3, {16'h0, w[i]});
        end
    endtask : t_decode
    // Read-only words, writes to the id and revision words ignored, unmapped place reads zero.
    task automatic t_regs();
        rd32(`CWRW_OFS_CW4, 32'h0000ffff);
        xfer(1'b1, `CWRW_OFS_PARTID, 32'h0);
        rd32(`CWRW_OFS_PARTID, {8'h00, 8'hff, `CWRW_FAMILY_ID, `CWRW_PART_ID});
        xfer(1'b1, `CWRW_OFS_REV, 32'hffffffff);
        rd32(`CWRW_OFS_REV, {28'h0, `CWRW_REVISION});
        rd32(8'h40, 32'h0);
    endtask : t_regs
    // Low-voltage flag raised, masked, unmasked and cleared.
    task automatic t_irq();
        xfer(1'b1, `CWRW_OFS_IRQ_FLAG_STATUS_FOUR, 32'h103);
        lv_det <= 1'b1;
        repeat (10) @(posedge i_ref_clk);
        lv_det <= 1'b0;
        rd32(`CWRW_OFS_IRQ_FLAG_STATUS_FOUR, 32'h100);
        chk({31'h0, irq}, 32'h0);
        xfer(1'b1, `CWRW_OFS_MASK, 32'h100);
        repeat (2) @(posedge i_ref_clk);
        chk({31'h0, irq}, 32'h1);
        xfer(1'b1, `CWRW_OFS_IRQ_FLAG_STATUS_FOUR, 32'h100);
        repeat (2) @(posedge i_ref_clk);
        chk({31'h0, irq}, 32'h0);
        rd32(`CWRW_OFS_IRQ_FLAG_STATUS_FOUR, 32'h0);
    endtask : t_irq
    // Supply too low: reset held, flag set, then a full hold-off on recovery.
    task automatic t_brown();
        sl_det <= 1'b1;
        repeat (12) @(posedge i_ref_clk);
        chk({30'h0, brown_rst, core_run}, 32'h2);
        sl_det <= 1'b0;
        repeat (12) @(posedge i_ref_clk);
        rd32(`CWRW_OFS_RESET_CONTROL_REG, 32'h2);
        rd32(`CWRW_OFS_IRQ_FLAG_STATUS_FOUR, 32'h2);
        wait_run(2400, 2540);
        xfer(1'b1, `CWRW_OFS_RESET_CONTROL_REG, 32'h2);
        rd32(`CWRW_OFS_RESET_CONTROL_REG, 32'h0);
    endtask : t_brown
    // Sleep then wake; checks standby level and the wake delay window.
    task automatic t_sleep(input logic sb, input int lo, input int hi);
        sleep_req <= 1'b1;
        @(posedge i_ref_clk);
        sleep_req <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        chk({30'h0, core_run, standby}, {31'h0, sb});
        wake_evt <= 1'b1;
        @(posedge i_ref_clk);
        wake_evt <= 1'b0;
        wait_run(lo, hi);
    endtask : t_sleep
    // ------------
    // Main sequence and verdict
    // ------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize
    initial begin
        i_rstn = 1'b0;
        {hsel, hwrite, lv_det, sl_det, sleep_req, wake_evt} = 6'h00;
        en_pin = 1'b1;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'b00;
        hsize = 3'b010;
        cw3 = 24'hffffff;
        cw4 = 24'hffffff;
        t_decode();
        rst(16'hdf3c);
        t_regs();
        wait_run(2400, 2540);
        rd32(`CWRW_OFS_IRQ_FLAG_STATUS_FOUR, 32'h1);
        t_irq();
        t_brown();
        t_sleep(1'b1, 2450, 2540);
        xfer(1'b1, `CWRW_OFS_RESET_CONTROL_REG, 32'h100);
        rd32(`CWRW_OFS_RESET_CONTROL_REG, 32'h100);
        t_sleep(1'b0, 0, 8);
        rst(16'h5520);
        wait_run(2400, 2540);
        t_sleep(1'b1, 1200, 1300);
        summarize();
    end
    // Watchdog: the run needs about 46 us, so 200 us means a hang.
    initial begin
        #200000;
        bad_count++;
        summarize();
    end
endmodule : config_word_and_regulator_wake_ctrl_test
